// file: hw/stmr_defs.svh
// stmr_defs.svh: register offsets, field positions, reset values, counts
// assumes: included by the timer core only, 32-bit apb word map
`ifndef STMR_DEFS_SVH
`define STMR_DEFS_SVH

// -------------------------------------------------------------------
// register byte offsets (one aligned word each)
// -------------------------------------------------------------------
`define STMR_OFF_CTRL0 12'h000
`define STMR_OFF_CTRL1 12'h004
`define STMR_OFF_CNT_LO 12'h008
`define STMR_OFF_CNT_HI 12'h00C
`define STMR_OFF_CMP_LO 12'h010
`define STMR_OFF_CMP_HI 12'h014
`define STMR_OFF_PRD 12'h018
`define STMR_OFF_STAT 12'h01C

// -------------------------------------------------------------------
// control 0 fields
// -------------------------------------------------------------------
`define STMR_C0_PAUSE 7
`define STMR_C0_CKS_HI 6
`define STMR_C0_CKS_LO 4
`define STMR_C0_RUN 3

// -------------------------------------------------------------------
// control 1 fields
// -------------------------------------------------------------------
`define STMR_C1_MODE_HI 7
`define STMR_C1_MODE_LO 6
`define STMR_C1_PFS_HI 5
`define STMR_C1_PFS_LO 4
`define STMR_C1_OIL 3
`define STMR_C1_POL 2
`define STMR_C1_DPX 1
`define STMR_C1_CCLR 0

// -------------------------------------------------------------------
// reset values
// -------------------------------------------------------------------
`define STMR_RST_CTRL0 8'h00
`define STMR_RST_CTRL1 8'h00
`define STMR_RST_BYTE 8'h00
`define STMR_RST_PRD 8'h00

// -------------------------------------------------------------------
// internal clock dividers (high clock taken as pclk, sub as /256)
// -------------------------------------------------------------------
`define STMR_DIV_SYS4 8'h03
`define STMR_DIV_H16 8'h0F
`define STMR_DIV_H64 8'h3F
`define STMR_DIV_SUB 8'hFF

`endif

// file: hw/stmr_pkg.sv
// stmr_pkg.sv: types shared by the standard timer core
// assumes: constants come from stmr_defs.svh
package stmr_pkg;

   // operating mode field encodings
   typedef enum logic [1:0] {
      STMR_MODE_CMP = 2'h0,
      STMR_MODE_CAP = 2'h1,
      STMR_MODE_PWM = 2'h2,
      STMR_MODE_TMR = 2'h3
   } stmr_mode_t;

   // pin group carried as one bundle
   typedef struct packed {
      logic ext_clock_pin;
      logic capture_input_pin;
   } stmr_pins_t;

   // apb request bundle
   typedef struct packed {
      logic sel;
      logic en;
      logic wr;
      logic [11:0] addr;
      logic [31:0] wdata;
   } stmr_apb_req_t;

endpackage

// file: hw/stmr_core.sv
// stmr_core.sv: standard timer core, 16-bit up-counter with apb registers
// assumes: pclk at 20 MHz, presetn async active low, pins asynchronous
//
// Behaviour
// [R1] 16-bit up-counter advanced by selected clock
// [R2] period compares top byte, fine compares all
// [R3] counter cleared by run-enable rising
// [R4] overflow or compare match clears counter
// [R5] low write buffered, high write commits both
// [R6] high read snapshots low into buffer
// [R7] software writes low first, reads high first
// [R8] counter pair read-only, fine compare read-write
// [R9] pause holds count, resume from held value
// [R10] three-bit clock select picks counting source
// [R11] instance one has no external clock pin
// [R12] run-enable low stops and powers down
// [R13] enable rise clears; fall keeps residual count
// [R14] enable rise restores output initial level
// [R15] single pulse triggered by external clock pin
// [R16] capture pin edge rising, falling or both
// [R17] compare match sets, clears or toggles output
// [R18] two-bit mode selects compare/capture/pwm/timer
// [R19] capture edge select, eleven disables capture
// [R20] external clock edges synchronised, counted once
`include "stmr_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module stmr_core #(
   parameter int INSTANCE = 0 // instance 1 lacks the external clock pin
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire stmr_pkg::stmr_pins_t pins_in,
   output logic timer_output_pin,
   output logic cmp_fine_event,
   output logic cmp_period_event
);

   // -------------------------------------------------------------------
   // register and state storage
   // -------------------------------------------------------------------
   logic [7:0] ctrl0_r, ctrl0_nxt; // pause, clock select, run enable
   logic [7:0] ctrl1_r, ctrl1_nxt; // mode, pin function, output control
   logic [7:0] cmp_lo_r, cmp_lo_nxt; // fine compare low byte
   logic [7:0] cmp_hi_r, cmp_hi_nxt; // fine compare high byte
   logic [7:0] prd_r, prd_nxt; // coarse period value
   logic [7:0] hold_r, hold_nxt; // shared 8-bit holding buffer
   logic [15:0] cnt_r, cnt_nxt; // main counter
   logic run_d_r; // run enable, previous cycle
   logic [7:0] div_r, div_nxt; // internal prescaler
   logic out_r, out_nxt; // output level before polarity
   logic cap_hit_r, cap_hit_nxt; // capture happened (status)
   logic [15:0] cap_r, cap_nxt; // captured count
   logic pulse_r, pulse_nxt; // single pulse in progress
   logic [2:0] ck_sync_r; // external clock pin synchroniser
   logic [2:0] cap_sync_r; // capture pin synchroniser
   logic ck_lvl_r, cap_lvl_r; // agreed levels

   // -------------------------------------------------------------------
   // field decode
   // -------------------------------------------------------------------
   logic run, pause, pol, oil, cclr;
   logic [2:0] cks;
   logic [1:0] pfs;
   stmr_pkg::stmr_mode_t mode;
   assign run = ctrl0_r[`STMR_C0_RUN];
   assign pause = ctrl0_r[`STMR_C0_PAUSE];
   assign cks = ctrl0_r[`STMR_C0_CKS_HI:`STMR_C0_CKS_LO];
   assign mode = stmr_pkg::stmr_mode_t'(
      ctrl1_r[`STMR_C1_MODE_HI:`STMR_C1_MODE_LO]);
   assign pfs = ctrl1_r[`STMR_C1_PFS_HI:`STMR_C1_PFS_LO];
   assign oil = ctrl1_r[`STMR_C1_OIL];
   assign pol = ctrl1_r[`STMR_C1_POL];
   assign cclr = ctrl1_r[`STMR_C1_CCLR];

   // apb phases; the slave answers at once, no wait states
   logic wr_acc, rd_acc;
   assign wr_acc = psel & penable & pwrite;
   assign rd_acc = psel & penable & ~pwrite;
   assign pready = 1'b1;

   // decode of the address, used for both reads and writes
   function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
      hit = (a == o);
   endfunction

   // unmapped addresses answer with an error
   assign pslverr = psel & penable & ~(hit(paddr, `STMR_OFF_CTRL0) |
      hit(paddr, `STMR_OFF_CTRL1) | hit(paddr, `STMR_OFF_CNT_LO) |
      hit(paddr, `STMR_OFF_CNT_HI) | hit(paddr, `STMR_OFF_CMP_LO) |
      hit(paddr, `STMR_OFF_CMP_HI) | hit(paddr, `STMR_OFF_PRD) |
      hit(paddr, `STMR_OFF_STAT));

   // -------------------------------------------------------------------
   // pin synchronisers: a change counts once stages two and three agree
   // -------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ck_sync_r <= 3'h0;
         cap_sync_r <= 3'h0;
         ck_lvl_r <= 1'b0;
         cap_lvl_r <= 1'b0;
      end else begin
         ck_sync_r <= {ck_sync_r[1:0], pins_in.ext_clock_pin}; // [R20]
         cap_sync_r <= {cap_sync_r[1:0], pins_in.capture_input_pin};
         if (ck_sync_r[1] == ck_sync_r[2]) begin
            ck_lvl_r <= ck_sync_r[2];
         end
         if (cap_sync_r[1] == cap_sync_r[2]) begin
            cap_lvl_r <= cap_sync_r[2];
         end
      end
   end

   // edge pulses from the agreed level, one per real edge
   logic ck_rise, ck_fall, cap_rise, cap_fall, has_ck_pin;
   assign has_ck_pin = (INSTANCE != 1); // [R11]
   assign ck_rise = has_ck_pin & ck_sync_r[2] & ~ck_lvl_r &
      (ck_sync_r[1] == ck_sync_r[2]); // [R20]
   assign ck_fall = has_ck_pin & ~ck_sync_r[2] & ck_lvl_r &
      (ck_sync_r[1] == ck_sync_r[2]);
   assign cap_rise = cap_sync_r[2] & ~cap_lvl_r &
      (cap_sync_r[1] == cap_sync_r[2]);
   assign cap_fall = ~cap_sync_r[2] & cap_lvl_r &
      (cap_sync_r[1] == cap_sync_r[2]);

   // -------------------------------------------------------------------
   // counting tick select
   // -------------------------------------------------------------------
   logic tick;
   always_comb begin
      div_nxt = run ? div_r + 8'h01 : 8'h00; // divider off when powered down
      case (cks) // [R10]
         3'h0: tick = (div_r & `STMR_DIV_SYS4) == `STMR_DIV_SYS4;
         3'h1: tick = 1'b1;
         3'h2: tick = (div_r & `STMR_DIV_H16) == `STMR_DIV_H16;
         3'h3: tick = (div_r & `STMR_DIV_H64) == `STMR_DIV_H64;
         3'h4, 3'h5: tick = (div_r & `STMR_DIV_SUB) == `STMR_DIV_SUB;
         3'h6: tick = ck_rise; // [R11]
         default: tick = ck_fall;
      endcase
   end

   // -------------------------------------------------------------------
   // counter, compare, output and register next-state
   // -------------------------------------------------------------------
   logic run_rise, cmp_a, cmp_p, ovf, adv, cap_edge;
   logic [15:0] cmp_val;
   assign cmp_val = {cmp_hi_r, cmp_lo_r};
   assign run_rise = run & ~run_d_r;
   // a single pulse mode only counts once triggered
   assign adv = run & ~pause & tick &
      ((mode != stmr_pkg::STMR_MODE_PWM) || pfs != 2'h3 || pulse_r); // [R9]
   assign cmp_a = adv && (cnt_r + 16'h0001) == cmp_val; // [R2]
   assign cmp_p = adv && prd_r != 8'h00 &&
      (cnt_r[15:8] + {7'h00, &cnt_r[7:0]}) == prd_r; // [R2]
   assign ovf = adv && cnt_r == 16'hFFFF;
   assign cap_edge = (pfs == 2'h0 && cap_rise) || // [R19]
      (pfs == 2'h1 && cap_fall) || (pfs == 2'h2 && (cap_rise | cap_fall));
   assign cmp_fine_event = cmp_a;
   assign cmp_period_event = cmp_p | (ovf & ~cclr);

   always_comb begin
      ctrl0_nxt = ctrl0_r;
      ctrl1_nxt = ctrl1_r;
      cmp_lo_nxt = cmp_lo_r;
      cmp_hi_nxt = cmp_hi_r;
      prd_nxt = prd_r;
      hold_nxt = hold_r;
      cnt_nxt = cnt_r;
      out_nxt = out_r;
      cap_nxt = cap_r;
      cap_hit_nxt = cap_hit_r;
      pulse_nxt = pulse_r;
      // counter: enable rise clears, else advance and auto-clear
      if (run_rise) begin
         cnt_nxt = 16'h0000; // [R3] [R13]
         out_nxt = oil; // [R14]
         pulse_nxt = 1'b0;
      end else if (adv) begin
         if ((cclr && cmp_a) || (!cclr && (cmp_p || ovf))) begin
            cnt_nxt = 16'h0000; // [R4]
            pulse_nxt = 1'b0;
         end else begin
            cnt_nxt = cnt_r + 16'h0001; // [R1]
         end
      end
      // while off the count keeps its residual value
      // output pin behaviour per mode
      if (!run_rise && run) begin
         case (mode) // [R18]
            stmr_pkg::STMR_MODE_CMP: begin
               if (cmp_a) begin
                  case (pfs) // [R17]
                     2'h1: out_nxt = 1'b0;
                     2'h2: out_nxt = 1'b1;
                     2'h3: out_nxt = ~out_r;
                     default: out_nxt = out_r;
                  endcase
               end
            end
            stmr_pkg::STMR_MODE_PWM: begin
               // pin function 2: active while below the duty compare; 0 and 1 fixed level, 3 single pulse
               if (pfs == 2'h0) out_nxt = ~oil;
               else if (pfs == 2'h1) out_nxt = oil;
               else if (pfs == 2'h2) out_nxt = (cnt_nxt < cmp_val) ? oil : ~oil;
               else out_nxt = pulse_r ? oil : ~oil; // [R17]
               if (pfs == 2'h3 && ck_rise) pulse_nxt = 1'b1; // [R15]
               if (pfs == 2'h3 && cmp_a) pulse_nxt = 1'b0;
            end
            stmr_pkg::STMR_MODE_CAP: begin
               if (cap_edge) begin // [R16]
                  cap_nxt = cnt_r;
                  cap_hit_nxt = 1'b1; // set wins over the clear below
               end
            end
            default: out_nxt = out_r;
         endcase
      end
      // apb writes
      if (wr_acc) begin
         if (hit(paddr, `STMR_OFF_CTRL0)) begin
            ctrl0_nxt = {pwdata[7:3], 3'h0};
         end else if (hit(paddr, `STMR_OFF_CTRL1)) begin
            ctrl1_nxt = pwdata[7:0];
         end else if (hit(paddr, `STMR_OFF_CMP_LO)) begin
            hold_nxt = pwdata[7:0]; // [R5]
         end else if (hit(paddr, `STMR_OFF_CMP_HI)) begin
            cmp_hi_nxt = pwdata[7:0]; // [R5] [R8]
            cmp_lo_nxt = hold_r; // [R7]
         end else if (hit(paddr, `STMR_OFF_PRD)) begin
            prd_nxt = pwdata[7:0];
         end else if (hit(paddr, `STMR_OFF_STAT)) begin
            if (pwdata[0] && !(cap_edge && mode == stmr_pkg::STMR_MODE_CAP
               && run)) cap_hit_nxt = 1'b0;
         end
      end
      // apb reads of a high byte snapshot the low byte
      if (rd_acc) begin
         if (hit(paddr, `STMR_OFF_CNT_HI)) begin
            hold_nxt = cnt_r[7:0]; // [R6]
         end else if (hit(paddr, `STMR_OFF_CMP_HI)) begin
            hold_nxt = cmp_lo_r; // [R6]
         end
      end
   end

   // -------------------------------------------------------------------
   // state registers
   // -------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl0_r <= `STMR_RST_CTRL0;
         ctrl1_r <= `STMR_RST_CTRL1;
         cmp_lo_r <= `STMR_RST_BYTE;
         cmp_hi_r <= `STMR_RST_BYTE;
         prd_r <= `STMR_RST_PRD;
         hold_r <= `STMR_RST_BYTE;
         cnt_r <= 16'h0000;
         run_d_r <= 1'b0;
         div_r <= 8'h00;
         out_r <= 1'b0;
         cap_r <= 16'h0000;
         cap_hit_r <= 1'b0;
         pulse_r <= 1'b0;
      end else begin
         ctrl0_r <= ctrl0_nxt;
         ctrl1_r <= ctrl1_nxt;
         cmp_lo_r <= cmp_lo_nxt;
         cmp_hi_r <= cmp_hi_nxt;
         prd_r <= prd_nxt;
         hold_r <= hold_nxt;
         cnt_r <= cnt_nxt; // [R12] holds while off
         run_d_r <= run;
         div_r <= div_nxt;
         out_r <= out_nxt;
         cap_r <= cap_nxt;
         cap_hit_r <= cap_hit_nxt;
         pulse_r <= pulse_nxt;
      end
   end

   // polarity applies outside timer/counter mode; output is registered
   logic pin_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_r <= 1'b0;
      end else begin
         pin_r <= (mode == stmr_pkg::STMR_MODE_TMR) ? 1'b0 : out_r ^ pol;
      end
   end
   assign timer_output_pin = pin_r;

   // -------------------------------------------------------------------
   // read data mux; low byte reads return the holding buffer
   // -------------------------------------------------------------------
   always_comb begin
      prdata = 32'h0000_0000;
      if (rd_acc) begin
         if (hit(paddr, `STMR_OFF_CTRL0)) prdata[7:0] = ctrl0_r;
         else if (hit(paddr, `STMR_OFF_CTRL1)) prdata[7:0] = ctrl1_r;
         else if (hit(paddr, `STMR_OFF_CNT_LO)) prdata[7:0] = hold_r; // [R6]
         else if (hit(paddr, `STMR_OFF_CNT_HI)) prdata[7:0] = cnt_r[15:8];
         else if (hit(paddr, `STMR_OFF_CMP_LO)) prdata[7:0] = hold_r;
         else if (hit(paddr, `STMR_OFF_CMP_HI)) prdata[7:0] = cmp_hi_r;
         else if (hit(paddr, `STMR_OFF_PRD)) prdata[7:0] = prd_r;
         else if (hit(paddr, `STMR_OFF_STAT)) prdata = {cap_r, 15'h0000,
            cap_hit_r};
      end
   end

endmodule
`default_nettype wire

// file: verif/stmr_pin_model.sv
// stmr_pin_model.sv: far-side pins of the timer core
// assumes: the bench clock drives it; the core syncs the pins itself
`timescale 1ns/1ps
`default_nettype none
module stmr_pin_model (
   input wire logic pclk,
   input wire logic clk_run,
   input wire logic cap_lvl,
   output stmr_pkg::stmr_pins_t pins
);
   localparam int HALF = 4; // pclk cycles per half period of the pin clock
   int cnt_r = 0; // cycles since the last pin edge
   logic ext_r = 1'b0; // external clock pin level
   // -----------------------------------------
   // pin clock
   // -----------------------------------------
   // toggles only while asked; slow enough that every edge must count once
   always @(posedge pclk) begin
      cnt_r <= (clk_run && cnt_r < HALF - 1) ? cnt_r + 1 : 0;
      if (clk_run && cnt_r == HALF - 1) begin
         ext_r <= !ext_r;
      end
   end
   assign pins = '{ext_clock_pin: ext_r, capture_input_pin: cap_lvl};
endmodule
`default_nettype wire

// file: verif/stmr_asserts.sv
// stmr_asserts.sv: bus and behaviour checks on the timer core ports
// assumes: bound to stmr_core; all registers start at zero
`timescale 1ns/1ps
`default_nettype none
module stmr_asserts (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic timer_output_pin,
   input wire logic cmp_fine_event,
   input wire logic cmp_period_event
);
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // --------------------------------------------
   // shadows of what software wrote
   // --------------------------------------------
   wire logic acc = psel && penable; // access phase
   logic [7:0] c0_r, c0_nxt, c1_r, c1_nxt; // control shadows
   logic [7:0] buf_r, buf_nxt; // holding buffer, shared by both pairs
   logic bv_r, bv_nxt; // counter snapshots are not modelled, so unknown
   logic [15:0] cmp_r, cmp_nxt; // committed fine compare value
   wire logic halt = !c0_r[3] || c0_r[7]; // stopped or paused
   wire logic tmr = c1_r[7:6] == 2'h3; // timer/counter mode
   always_comb begin
      c0_nxt = c0_r;
      c1_nxt = c1_r;
      buf_nxt = buf_r;
      bv_nxt = bv_r;
      cmp_nxt = cmp_r;
      if (acc) begin
         case ({pwrite, paddr})
            13'h1000: c0_nxt = pwdata[7:0];
            13'h1004: c1_nxt = pwdata[7:0];
            13'h1010: begin
               buf_nxt = pwdata[7:0];
               bv_nxt = 1'b1;
            end
            13'h1014: cmp_nxt = {pwdata[7:0], buf_r};
            13'h0014: begin
               buf_nxt = cmp_r[7:0];
               bv_nxt = 1'b1;
            end
            13'h000C: bv_nxt = 1'b0;
            default: ;
         endcase
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         c0_r <= 8'h00;
         c1_r <= 8'h00;
         buf_r <= 8'h00;
         bv_r <= 1'b1;
         cmp_r <= 16'h0000;
      end else begin
         c0_r <= c0_nxt;
         c1_r <= c1_nxt;
         buf_r <= buf_nxt;
         bv_r <= bv_nxt;
         cmp_r <= cmp_nxt;
      end
   end
   // --------------------------------------------
   // properties
   // --------------------------------------------
   sequence rd_s(logic [11:0] a);
      acc && !pwrite && paddr == a;
   endsequence
   sequence run_rise_s;
      acc && pwrite && paddr == 12'h000 && pwdata[3] && !c0_r[3];
   endsequence
   idle_rdata_a: assert property (!acc |-> prdata == 32'h0)
      else $error("read data not zero outside access");
   err_unmapped_a: assert property (
      acc && paddr > 12'h01C |-> pslverr && pready)
      else $error("unmapped address not refused");
   ctrl_pad_a: assert property (
      rd_s(12'h000) |-> prdata[2:0] == 3'h0)
      else $error("control 0 low bits not zero");
   cmp_high_a: assert property (
      rd_s(12'h014) |-> prdata[7:0] == cmp_r[15:8])
      else $error("fine compare high byte wrong");
   buf_low_a: assert property (
      rd_s(12'h010) ##0 bv_r |-> prdata[7:0] == buf_r)
      else $error("low byte not from holding buffer");
   halt_quiet_a: assert property (
      halt && $past(halt) |-> !cmp_fine_event && !cmp_period_event)
      else $error("event while stopped or paused");
   run_level_a: assert property (
      run_rise_s ##0 (c1_r[7:6] == 2'h0 && !c1_r[2])
      |-> ##3 timer_output_pin == c1_r[3])
      else $error("output not at initial level after start");
   timer_out_a: assert property (
      tmr && $past(tmr) |-> !timer_output_pin)
      else $error("output driven in timer mode");
endmodule
bind stmr_core stmr_asserts i_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .timer_output_pin(timer_output_pin), .cmp_fine_event(cmp_fine_event),
   .cmp_period_event(cmp_period_event));
`default_nettype wire

// file: verif/testbench.sv
// testbench.sv: self-checking bench for the standard timer core
// assumes: package, core, pin model and checker compiled before it
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic pclk = 1'b0; // 20 MHz
   logic presetn = 1'b0; // held low for 8 cycles
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rdq; // bus data, last read taken
   logic pready, pslverr, errq; // answer, last error taken
   logic tout, evf, evp; // output pin and event pulses
   logic ext_run = 1'b0, cap_lvl = 1'b0; // partner requests
   stmr_pkg::stmr_pins_t pins;
   int num_errors = 0, check_count = 0, cycles = 0;
   stmr_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins_in(pins),
      .timer_output_pin(tout), .cmp_fine_event(evf),
      .cmp_period_event(evp));
   stmr_pin_model i_pins (.pclk(pclk), .clk_run(ext_run),
      .cap_lvl(cap_lvl), .pins(pins));
   initial begin
      forever #25 pclk = ~pclk;
   end
   // -----------------------------------------
   // shared tasks
   // -----------------------------------------
   task automatic tally_and_finish();
      $display("checks %0d, errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask
   // request held until pready is seen; one idle cycle after
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdq = prdata;
      errq = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [11:0] a);
      apb(1'b0, a, 32'h0);
   endtask
   task automatic rdcnt(output logic [15:0] v);
      rd(12'h00C); // high byte first
      v[15:8] = rdq[7:0];
      rd(12'h008);
      v[7:0] = rdq[7:0];
   endtask
   // cycles until the next event pulse, bounded
   task automatic wait_ev(input logic per, output int n);
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while ((per ? evp : evf) !== 1'b1 && n < 4000);
   endtask
   // -----------------------------------------
   // scenarios
   // -----------------------------------------
   task automatic t_regs();
      for (int a = 0; a < 28; a += 4) begin
         rd(a[11:0]);
         chk("reset value", rdq, 32'h0);
      end
      rd(12'h020);
      chk("unmapped error", errq, 1'b1);
      wr(12'h010, 32'h34);
      wr(12'h014, 32'h12);
      wr(12'h010, 32'h56); // low only: must stay in the buffer
      rd(12'h014);
      chk("compare high", rdq, 32'h12);
      rd(12'h010);
      chk("compare low", rdq, 32'h34);
      wr(12'h00C, 32'hFF);
      wr(12'h008, 32'hFF);
      rd(12'h00C);
      chk("counter read-only", rdq, 32'h0);
   endtask
   task automatic t_clk();
      // fine match at 3 clears the count before it shows 3: 3 ticks a period
      int gaps [8] = '{12, 3, 48, 192, 768, 768, 24, 24};
      int g;
      wr(12'h010, 32'h03);
      wr(12'h014, 32'h00);
      wr(12'h004, 32'hC1); // timer mode, clear on fine match
      for (int k = 0; k < 8; k++) begin
         ext_run <= (k > 5);
         wr(12'h000, {25'h0, k[2:0], 4'h8});
         wait_ev(1'b0, g);
         wait_ev(1'b0, g);
         chk("fine gap", g, gaps[k]);
         wr(12'h000, 32'h0);
      end
      ext_run <= 1'b0;
      wr(12'h004, 32'hC0); // clear on period match
      for (int p = 1; p < 3; p++) begin
         wr(12'h018, p);
         wr(12'h000, 32'h18);
         wait_ev(1'b1, g);
         wait_ev(1'b1, g);
         chk("period gap", g, p * 256);
         wr(12'h000, 32'h0);
      end
   endtask
   task automatic t_pause();
      logic [15:0] v1, v2;
      wr(12'h004, 32'hC1);
      wr(12'h014, 32'hFF); // far match, commits buffer too
      wr(12'h000, 32'h08);
      repeat (40) @(posedge pclk);
      wr(12'h000, 32'h88);
      rdcnt(v1);
      repeat (20) @(posedge pclk);
      rdcnt(v2);
      chk("paused count", v2, v1);
      wr(12'h000, 32'h08);
      repeat (20) @(posedge pclk);
      rdcnt(v2);
      chk("resumed count", v2 > v1, 1'b1);
      wr(12'h000, 32'h00);
      rdcnt(v1);
      repeat (20) @(posedge pclk);
      rdcnt(v2);
      chk("stopped count", v2, v1);
      wr(12'h000, 32'h08);
      rdcnt(v2);
      chk("cleared on start", v2 < 16'h0004, 1'b1);
      wr(12'h000, 32'h00);
   endtask
   task automatic t_out();
      logic oil, ex;
      int g;
      wr(12'h010, 32'h03);
      wr(12'h014, 32'h00);
      for (int f = 3; f > 0; f--) begin
         oil = (f == 1);
         ex = (f == 3) ? !oil : (f == 2);
         wr(12'h004, {26'h0, f[1:0], oil, 3'h1});
         wr(12'h000, 32'h18);
         // level set one edge after the start, registered onto the pin next
         repeat (2) @(posedge pclk);
         chk("initial level", tout, oil);
         wait_ev(1'b0, g);
         repeat (2) @(posedge pclk);
         chk("match level", tout, ex);
         wr(12'h000, 32'h00);
      end
   endtask
   task automatic t_cap();
      logic ex;
      for (int f = 0; f < 4; f++) begin
         wr(12'h004, {26'h1, f[1:0], 4'h0});
         wr(12'h000, 32'h18);
         for (int e = 1; e >= 0; e--) begin
            ex = e ? (f == 0 || f == 2) : (f == 1 || f == 2);
            wr(12'h01C, 32'h01);
            cap_lvl <= e[0];
            repeat (8) @(posedge pclk);
            rd(12'h01C);
            chk("capture flag", rdq[0], ex);
         end
         wr(12'h000, 32'h00);
      end
   endtask
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 30000) begin
         num_errors++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs();
      t_clk();
      t_pause();
      t_out();
      t_cap();
      tally_and_finish();
   end
endmodule
`default_nettype wire
